// ---- logic/rsr_top.sv ----
/*
 axi4-lite front end of the two-channel remote signal receiver registers.
 assumes decoder logic on aclk supplies received bits and status words;
 channel 0 at byte offset 0x000, channel 1 at 0x100 of this slave.
*/
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rsr_defines.svh"
module rsr_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [`RSR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [`RSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // from the bit decoder, one lane per channel
   input wire logic [1:0] rx_bit_valid,
   input wire logic [1:0] rx_bit_value,
   input wire logic [1:0] rx_frame_start,
   input wire logic [1:0][31:0] rx_state,
   // to the receiver core, one lane per channel
   output logic [1:0] module_on,
   output logic [1:0] reception_on,
   output logic [1:0] sample_from_timer,
   output logic [1:0][31:0] leader_timing_control,
   output logic [1:0][31:0] receive_control_two,
   output logic [1:0][31:0] receive_control_three,
   output logic [1:0][31:0] receive_control_four,
   output logic [1:0][31:0] end_bit_count_one,
   output logic [1:0][31:0] end_bit_count_two,
   output logic [1:0][31:0] end_bit_count_three
);
   rsr_pkg::rsr_wr_state_e wr_state;
   rsr_pkg::rsr_rd_state_e rd_state;
   logic aw_held;
   logic w_held;
   logic [`RSR_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic wr_hit;
   logic rd_hit;
   logic next_aw_held;
   logic next_w_held;
   logic [1:0][31:0] ch_rd_data;

   // a hole in the map answers slverr; mapped read-only slots answer okay
   function automatic logic addr_mapped(input logic [`RSR_ADDR_W-1:0] a);
      return a[`RSR_TOP_MSB:`RSR_TOP_LSB] == '0 && a[1:0] == 2'h0
         && a[`RSR_OFF_MSB:0] <= `RSR_OFF_FSSEL; // RULE1
   endfunction

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   // write only once both halves are in and the last response is gone
   assign do_write = aw_held && w_held && wr_state == rsr_pkg::RSR_W_IDLE;
   assign wr_hit = addr_mapped(aw_addr);
   assign rd_hit = addr_mapped(s_axi_araddr);
   assign next_aw_held = (aw_held || aw_take) && !do_write;
   assign next_w_held = (w_held || w_take) && !do_write;

   // address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr <= '0;
      end else begin
         aw_held <= next_aw_held;
         s_axi_awready <= !next_aw_held;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         w_held <= next_w_held;
         s_axi_wready <= !next_w_held;
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= rsr_pkg::RSR_W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RSR_RESP_OKAY;
      end else begin
         case (wr_state)
            rsr_pkg::RSR_W_IDLE: begin
               if (do_write) begin
                  wr_state <= rsr_pkg::RSR_W_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? `RSR_RESP_OKAY : `RSR_RESP_SLVERR;
               end
            end
            rsr_pkg::RSR_W_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= rsr_pkg::RSR_W_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state <= rsr_pkg::RSR_W_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // read data is captured at the address handshake, one cycle to rvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= rsr_pkg::RSR_R_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RSR_RESP_OKAY;
      end else begin
         case (rd_state)
            rsr_pkg::RSR_R_IDLE: begin
               s_axi_arready <= !ar_take;
               if (ar_take) begin
                  rd_state <= rsr_pkg::RSR_R_DATA;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_hit ? ch_rd_data[s_axi_araddr[`RSR_CH_SEL_BIT]] : '0;
                  s_axi_rresp <= rd_hit ? `RSR_RESP_OKAY : `RSR_RESP_SLVERR;
               end
            end
            rsr_pkg::RSR_R_DATA: begin
               if (s_axi_rready) begin
                  rd_state <= rsr_pkg::RSR_R_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: begin
               rd_state <= rsr_pkg::RSR_R_IDLE;
               s_axi_rvalid <= 1'b0;
            end
         endcase
      end
   end

   rsr_chan_if chif[2] ();

   for (genvar g = 0; g < 2; g++) begin : g_ch
      logic [`RSR_RXBITS-1:0] bits;
      logic shift_en;

      // no shifting while the channel is off or reception is blocked
      assign shift_en = rx_bit_valid[g] && chif[g].module_on && chif[g].reception_on; // RULE3 RULE5

      assign chif[g].wr_en = do_write && wr_hit && aw_addr[`RSR_CH_SEL_BIT] == g; // RULE1
      assign chif[g].wr_off = aw_addr[`RSR_OFF_MSB:0];
      assign chif[g].wr_data = w_data;
      assign chif[g].wr_strb = w_strb;
      assign chif[g].rd_off = s_axi_araddr[`RSR_OFF_MSB:0];
      assign chif[g].rx_bits = bits;
      assign chif[g].rx_state = rx_state[g];
      assign ch_rd_data[g] = chif[g].rd_data;

      assign module_on[g] = chif[g].module_on;
      assign reception_on[g] = chif[g].reception_on;
      assign sample_from_timer[g] = chif[g].sample_from_timer;
      assign leader_timing_control[g] = chif[g].leader_timing;
      assign receive_control_two[g] = chif[g].ctrl_two;
      assign receive_control_three[g] = chif[g].ctrl_three;
      assign receive_control_four[g] = chif[g].ctrl_four;
      assign end_bit_count_one[g] = chif[g].end_one;
      assign end_bit_count_two[g] = chif[g].end_two;
      assign end_bit_count_three[g] = chif[g].end_three;

      rsr_channel u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .cif(chif[g].chan)
      );

      rsr_rx_shift u_shift (
         .aclk(aclk),
         .aresetn(aresetn),
         .shift_en(shift_en),
         .bit_in(rx_bit_value[g]),
         .clear(rx_frame_start[g] && chif[g].module_on),
         .bits(bits)
      );
   end
endmodule

// ---- logic/rsr_defines.svh ----
/*
 constants for the two-channel remote signal receiver register front end.
 assumes inclusion by bare name from every design file that needs them.
*/
// Behaviour
// RULE1: two identical channels, each its own register block, word offsets zero to 0x34.
// RULE2: enable bit 0 turns channel off at 0, on at 1; set first.
// RULE3: channel off stops all internal activity except the enable register.
// RULE4: disabling a channel keeps all written configuration unchanged.
// RULE5: reception bit 0 allows reception at 1, blocks it at 0.
// RULE6: software programs control registers one to three before enabling reception.
// RULE7: first data buffer reads received bits 31 to 0, read only.
// RULE8: second data buffer reads received bits 63 to 32, read only.
// RULE9: third data buffer reads bits 71 to 64 low byte, rest zero.
// RULE10: bits enter msb first; newest received bit lands in bit 0.
// RULE11: sampling clock selectable between low-frequency clock and timer output.
// RULE12: writes to read-only or reserved bits ignored; reserved bits read zero.
// RULE13: software writes 1 to enable register bit 1 on every write.
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

`define RSR_ADDR_W 12
`define RSR_CH_SEL_BIT 8
`define RSR_OFF_MSB 7
`define RSR_TOP_MSB 11
`define RSR_TOP_LSB 9

`define RSR_OFF_EN 8'h00
`define RSR_OFF_REN 8'h04
`define RSR_OFF_BUF1 8'h08
`define RSR_OFF_BUF2 8'h0C
`define RSR_OFF_BUF3 8'h10
`define RSR_OFF_RCR1 8'h14
`define RSR_OFF_RCR2 8'h18
`define RSR_OFF_RCR3 8'h1C
`define RSR_OFF_RCR4 8'h20
`define RSR_OFF_STAT 8'h24
`define RSR_OFF_END1 8'h28
`define RSR_OFF_END2 8'h2C
`define RSR_OFF_END3 8'h30
`define RSR_OFF_FSSEL 8'h34

`define RSR_BIT_ON 0
`define RSR_BIT_FIXED 1
`define RSR_BIT_REN 0
`define RSR_BIT_FSSEL 0

`define RSR_RST_ZERO 32'h0000_0000
`define RSR_RST_RCR2 32'h0000_FFFF
`define RSR_RXBITS 72
`define RSR_BUF3_W 8

`define RSR_RESP_OKAY 2'h0
`define RSR_RESP_SLVERR 2'h2

`endif

// ---- logic/rsr_pkg.sv ----
/*
 types shared by the receiver register front end.
 assumes nothing beyond a systemverilog compiler.
*/
package rsr_pkg;
   typedef logic [31:0] rsr_word_t;
   typedef enum logic {RSR_W_IDLE, RSR_W_RESP} rsr_wr_state_e;
   typedef enum logic {RSR_R_IDLE, RSR_R_DATA} rsr_rd_state_e;
endpackage

// ---- logic/rsr_chan_if.sv ----
/*
 carrier between the bus front end and one channel register block.
 assumes one instance per channel, all on aclk.
*/
`timescale 1ns/1ns
interface rsr_chan_if;
   logic wr_en;
   logic [7:0] wr_off;
   rsr_pkg::rsr_word_t wr_data;
   logic [3:0] wr_strb;
   logic [7:0] rd_off;
   rsr_pkg::rsr_word_t rd_data;
   logic [71:0] rx_bits;
   rsr_pkg::rsr_word_t rx_state;
   logic module_on;
   logic reception_on;
   logic sample_from_timer;
   rsr_pkg::rsr_word_t leader_timing;
   rsr_pkg::rsr_word_t ctrl_two;
   rsr_pkg::rsr_word_t ctrl_three;
   rsr_pkg::rsr_word_t ctrl_four;
   rsr_pkg::rsr_word_t end_one;
   rsr_pkg::rsr_word_t end_two;
   rsr_pkg::rsr_word_t end_three;

   modport bus (
      output wr_en, wr_off, wr_data, wr_strb, rd_off, rx_bits, rx_state,
      input rd_data, module_on, reception_on, sample_from_timer, leader_timing,
      input ctrl_two, ctrl_three, ctrl_four, end_one, end_two, end_three
   );
   modport chan (
      input wr_en, wr_off, wr_data, wr_strb, rd_off, rx_bits, rx_state,
      output rd_data, module_on, reception_on, sample_from_timer, leader_timing,
      output ctrl_two, ctrl_three, ctrl_four, end_one, end_two, end_three
   );
endinterface

// ---- logic/rsr_rx_shift.sv ----
/*
 received-bit buffer of one channel, 72 bits, newest bit at bit 0.
 assumes bit strobes from decoder logic on aclk, already gated.
*/
`timescale 1ns/1ns
`include "rsr_defines.svh"
module rsr_rx_shift (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bit stream
   input wire logic shift_en,
   input wire logic bit_in,
   input wire logic clear,
   // held bits
   output logic [`RSR_RXBITS-1:0] bits
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bits <= '0;
      end else if (clear) begin
         bits <= '0;
      end else if (shift_en) begin
         // older bits move up so the frame reads msb first
         bits <= {bits[`RSR_RXBITS-2:0], bit_in}; // RULE10
      end
   end
endmodule

// ---- logic/rsr_channel.sv ----
/*
 register block of one receiver channel.
 assumes single-cycle write strobes and a combinational read port.
*/
`timescale 1ns/1ns
`include "rsr_defines.svh"
module rsr_channel (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // front end side
   rsr_chan_if.chan cif
);
   logic fixed_one;
   logic cfg_we;

   function automatic rsr_pkg::rsr_word_t merge(input rsr_pkg::rsr_word_t old,
         input rsr_pkg::rsr_word_t nw, input logic [3:0] strb);
      rsr_pkg::rsr_word_t r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // config writes only land while the channel runs: module_on gates the write enable
   assign cfg_we = cif.wr_en && cif.module_on; // RULE3

   // enable register takes writes whether or not the channel runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif.module_on <= 1'b0;
         fixed_one <= 1'b0;
      end else if (cif.wr_en && cif.wr_off == `RSR_OFF_EN && cif.wr_strb[0]) begin
         cif.module_on <= cif.wr_data[`RSR_BIT_ON]; // RULE2
         fixed_one <= cif.wr_data[`RSR_BIT_FIXED];
      end
   end

   // nothing here clears on disable, so settings survive an off period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif.reception_on <= 1'b0;
         cif.sample_from_timer <= 1'b0;
         cif.leader_timing <= `RSR_RST_ZERO;
         cif.ctrl_two <= `RSR_RST_RCR2;
         cif.ctrl_three <= `RSR_RST_ZERO;
         cif.ctrl_four <= `RSR_RST_ZERO;
         cif.end_one <= `RSR_RST_ZERO;
         cif.end_two <= `RSR_RST_ZERO;
         cif.end_three <= `RSR_RST_ZERO;
      end else if (cfg_we) begin // RULE4
         case (cif.wr_off)
            `RSR_OFF_REN: begin
               if (cif.wr_strb[0]) begin
                  cif.reception_on <= cif.wr_data[`RSR_BIT_REN]; // RULE5
               end
            end
            `RSR_OFF_RCR1: cif.leader_timing <= merge(cif.leader_timing, cif.wr_data, cif.wr_strb);
            `RSR_OFF_RCR2: cif.ctrl_two <= merge(cif.ctrl_two, cif.wr_data, cif.wr_strb);
            `RSR_OFF_RCR3: cif.ctrl_three <= merge(cif.ctrl_three, cif.wr_data, cif.wr_strb);
            `RSR_OFF_RCR4: cif.ctrl_four <= merge(cif.ctrl_four, cif.wr_data, cif.wr_strb);
            `RSR_OFF_END1: cif.end_one <= merge(cif.end_one, cif.wr_data, cif.wr_strb);
            `RSR_OFF_END2: cif.end_two <= merge(cif.end_two, cif.wr_data, cif.wr_strb);
            `RSR_OFF_END3: cif.end_three <= merge(cif.end_three, cif.wr_data, cif.wr_strb);
            `RSR_OFF_FSSEL: begin
               if (cif.wr_strb[0]) begin
                  cif.sample_from_timer <= cif.wr_data[`RSR_BIT_FSSEL]; // RULE11
               end
            end
            // buffers and status are read only
            default: ; // RULE12
         endcase
      end
   end

   always_comb begin
      cif.rd_data = `RSR_RST_ZERO; // RULE12
      case (cif.rd_off)
         `RSR_OFF_EN: begin
            cif.rd_data[`RSR_BIT_ON] = cif.module_on;
            cif.rd_data[`RSR_BIT_FIXED] = fixed_one;
         end
         `RSR_OFF_REN: cif.rd_data[`RSR_BIT_REN] = cif.reception_on;
         `RSR_OFF_BUF1: cif.rd_data = cif.rx_bits[31:0]; // RULE7
         `RSR_OFF_BUF2: cif.rd_data = cif.rx_bits[63:32]; // RULE8
         `RSR_OFF_BUF3: cif.rd_data[`RSR_BUF3_W-1:0] = cif.rx_bits[71:64]; // RULE9
         `RSR_OFF_RCR1: cif.rd_data = cif.leader_timing;
         `RSR_OFF_RCR2: cif.rd_data = cif.ctrl_two;
         `RSR_OFF_RCR3: cif.rd_data = cif.ctrl_three;
         `RSR_OFF_RCR4: cif.rd_data = cif.ctrl_four;
         `RSR_OFF_STAT: cif.rd_data = cif.rx_state;
         `RSR_OFF_END1: cif.rd_data = cif.end_one;
         `RSR_OFF_END2: cif.rd_data = cif.end_two;
         `RSR_OFF_END3: cif.rd_data = cif.end_three;
         `RSR_OFF_FSSEL: cif.rd_data[`RSR_BIT_FSSEL] = cif.sample_from_timer;
         default: cif.rd_data = `RSR_RST_ZERO;
      endcase
   end
endmodule

// ---- bench/rsr_top_properties.sv ----
/*
 port-level assertions for the remote signal receiver register front end.
 assumes binding onto rsr_top, one clock, synchronous low reset.
*/
`timescale 1ns/1ns
`include "rsr_defines.svh"
module rsr_top_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [`RSR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [`RSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // core side
   input wire logic [1:0] module_on,
   input wire logic [1:0] reception_on,
   input wire logic [1:0][31:0] leader_timing_control,
   input wire logic [1:0][31:0] receive_control_two
);
   logic [`RSR_ADDR_W-1:0] ra;
   logic wt;
   // fresh write only: a pending response delays the next one
   assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer not next cycle");
   property p_wr_lat; wt |-> ##2 s_axi_bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_bad;
      s_axi_rvalid && (ra[11:9] != 0 || ra[1:0] != 0 || ra[7:0] > 8'h34)
         |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
   property p_ok;
      s_axi_rvalid && ra[11:9] == 0 && ra[1:0] == 0 && ra[7:0] <= 8'h34 |-> s_axi_rresp == 2'h0;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped read refused");
   property p_buf3; s_axi_rvalid && ra[7:0] == 8'h10 |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_buf3: assert property (p_buf3) else $error("upper buffer bits not zero");
   property p_rsv; s_axi_rvalid && ra[7:0] == 8'h00 |-> s_axi_rdata[31:2] == 30'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved enable bits not zero");
   property p_on;
      wt && s_axi_awaddr == 12'h000 && s_axi_wstrb[0] |-> ##2 module_on[0] == $past(s_axi_wdata[0], 2);
   endproperty
   a_on: assert property (p_on) else $error("enable bit not taken");
   property p_ren;
      wt && s_axi_awaddr == 12'h004 && s_axi_wstrb[0] && module_on[0]
         |-> ##2 reception_on[0] == $past(s_axi_wdata[0], 2);
   endproperty
   a_ren: assert property (p_ren) else $error("reception bit not taken");
   property p_off; !module_on[0] |=> $stable(leader_timing_control[0]); endproperty
   a_off: assert property (p_off) else $error("config moved while off");
   property p_keep; $fell(module_on[0]) |-> $stable(receive_control_two[0]); endproperty
   a_keep: assert property (p_keep) else $error("config lost on disable");
   c_on: cover property (wt && s_axi_awaddr == 12'h000);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_off: cover property ($fell(module_on[0]));
endmodule

bind rsr_top rsr_top_properties chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .module_on, .reception_on, .leader_timing_control, .receive_control_two);

// ---- bench/rsr_bit_source.sv ----
/*
 model of a demodulated remote signal source feeding one bit lane.
 assumes the bench pulses go for one cycle and waits on busy.
*/
`timescale 1ns/1ns
module rsr_bit_source (
   // clock
   input wire logic aclk,
   // bench control
   input wire logic go,
   input wire logic slow,
   input wire logic [6:0] nbits,
   input wire logic [71:0] pattern,
   // bit lane
   output logic bit_valid,
   output logic bit_value,
   output logic frame_start,
   output logic busy
);
   logic [6:0] left;
   logic [1:0] gap;
   initial begin
      bit_valid = 1'b0;
      bit_value = 1'b0;
      frame_start = 1'b0;
      busy = 1'b0;
   end
   always @(posedge aclk) begin
      frame_start <= go && !busy;
      bit_valid <= 1'b0;
      // no bit present: value line toggles so no stale bit can pass
      bit_value <= ~bit_value;
      if (go && !busy) begin
         busy <= 1'b1;
         left <= nbits;
         gap <= 2'h0;
      end else if (busy) begin
         if (left == 7'h0) busy <= 1'b0;
         else if (gap != 2'h0) gap <= gap - 2'h1;
         else begin
            bit_valid <= 1'b1;
            bit_value <= pattern[left-7'h1];
            left <= left - 7'h1;
            gap <= slow ? 2'h2 : 2'h0;
         end
      end
   end
endmodule

// ---- bench/remote_ctrl_rx_regs_test.sv ----
/*
 self-checking bench for the remote signal receiver register front end.
 assumes rsr_top with its bound checker and two bit source models.
*/
`timescale 1ns/1ns
module remote_ctrl_rx_regs_test;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_bit_valid, rx_bit_value, rx_frame_start;
   logic [1:0] module_on, reception_on, sample_from_timer, go = 2'h0, busy;
   logic [1:0][31:0] rx_state = '0, leader_timing_control, receive_control_two;
   logic [1:0][31:0] receive_control_three, receive_control_four;
   logic [1:0][31:0] end_bit_count_one, end_bit_count_two, end_bit_count_three;
   logic slow = 1'b0;
   logic [6:0] nbits = 7'h0;
   logic [71:0] pat = 72'h0, p;
   logic [31:0] mdl [2][14];
   logic [11:0] bad [4] = '{12'h038, 12'h206, 12'h13C, 12'h105};
   int err_count = 0, cmp_count = 0, c, i, n;

   always #5 aclk = ~aclk;
   rsr_top uut (.*);
   for (genvar g = 0; g < 2; g++) begin : g_src
      rsr_bit_source src (.aclk, .go(go[g]), .slow, .nbits, .pattern(pat),
         .bit_valid(rx_bit_valid[g]), .bit_value(rx_bit_value[g]),
         .frame_start(rx_frame_start[g]), .busy(busy[g]));
   end

   function automatic logic [11:0] addr(input int c, i);
      return 12'(c * 256 + i * 4);
   endfunction
   // writable bits of each register slot; status and buffers take nothing
   function automatic logic [31:0] upd(input logic [31:0] o, d, input logic [3:0] s, input int i);
      logic [31:0] m;
      case (i)
         0: m = 32'h3;
         1, 13: m = 32'h1;
         5, 6, 7, 8, 10, 11, 12: m = 32'hFFFF_FFFF;
         default: m = 32'h0;
      endcase
      m = m & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (d & m);
   endfunction
   task automatic chk(input logic [31:0] g, e, input string m);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            done = 1;
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            done = 1;
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, e, "rdata");
            chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
         end
      end
   endtask
   // writes while the channel is off are dropped, except the enable itself
   task automatic wrm(input int c, i, input logic [31:0] d, input logic [3:0] s);
      wr(addr(c, i), d, s, 2'h0);
      if (i == 0 || mdl[c][0][0]) mdl[c][i] = upd(mdl[c][i], d, s, i);
   endtask
   task automatic frame(input int c, k, input logic [71:0] v, input logic sl);
      @(posedge aclk);
      nbits <= 7'(k);
      pat <= v;
      slow <= sl;
      go[c] <= 1'b1;
      @(posedge aclk);
      go[c] <= 1'b0;
      repeat (2) @(posedge aclk);
      while (busy[c]) @(posedge aclk);
   endtask
   task automatic chkbuf(input int c, input logic [71:0] b);
      rd(addr(c, 2), b[31:0], 2'h0);
      rd(addr(c, 3), b[63:32], 2'h0);
      rd(addr(c, 4), {24'h0, b[71:64]}, 2'h0);
   endtask
   task test_done;
      if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      err_count++;
      test_done;
   end
   initial begin
      void'($urandom(32'hC94F));
      repeat (8) @(posedge aclk);
      rx_state <= {$urandom, $urandom};
      aresetn <= 1'b1;
      for (c = 0; c < 2; c++) begin
         for (i = 0; i < 14; i++) begin
            mdl[c][i] = (i == 6) ? 32'h0000_FFFF : (i == 9) ? rx_state[c] : 32'h0;
            rd(addr(c, i), mdl[c][i], 2'h0);
         end
      end
      for (c = 0; c < 2; c++) begin
         wrm(c, 5, $urandom, 4'hF);
         rd(addr(c, 5), mdl[c][5], 2'h0);
         wrm(c, 0, 32'hFFFF_FFFF, 4'hF);
         rd(addr(c, 0), 32'h3, 2'h0);
         for (i = 5; i < 8; i++) wrm(c, i, $urandom, 4'hF);
         wrm(c, 1, 32'hFFFF_FFFF, 4'hF);
      end
      chk({28'h0, reception_on, module_on}, 32'hF, "on");
      for (n = 0; n < 120; n++) begin
         c = $urandom_range(1);
         i = $urandom_range(13);
         // enable writes keep bit 1 set, as software must
         if ($urandom_range(1)) wrm(c, i, $urandom | (i == 0 ? 32'h2 : 32'h0), 4'($urandom));
         else rd(addr(c, i), mdl[c][i], 2'h0);
      end
      chk({30'h0, sample_from_timer}, {30'h0, mdl[1][13][0], mdl[0][13][0]}, "fs");
      for (c = 0; c < 2; c++) begin
         chk(leader_timing_control[c], mdl[c][5], "o5");
         chk(receive_control_three[c], mdl[c][7], "o7");
         chk(receive_control_four[c], mdl[c][8], "o8");
         chk(end_bit_count_one[c], mdl[c][10], "o10");
         chk(end_bit_count_two[c], mdl[c][11], "o11");
         chk(end_bit_count_three[c], mdl[c][12], "o12");
      end
      wrm(0, 0, 32'h2, 4'hF);
      for (i = 1; i < 14; i++) rd(addr(0, i), mdl[0][i], 2'h0);
      chk(receive_control_two[0], mdl[0][6], "kept");
      for (c = 0; c < 2; c++) begin
         wrm(c, 0, 32'h3, 4'h1);
         wrm(c, 1, 32'h1, 4'h1);
      end
      p = {8'($urandom), $urandom, $urandom};
      frame(0, 72, p, 1'b0);
      chkbuf(0, p);
      frame(1, 9, p, 1'b1);
      chkbuf(1, {63'h0, p[8:0]});
      wrm(1, 1, 32'h0, 4'h1);
      frame(1, 5, ~p, 1'b0);
      chkbuf(1, 72'h0);
      wrm(0, 0, 32'h2, 4'h1);
      frame(0, 6, ~p, 1'b0);
      chkbuf(0, p);
      foreach (bad[k]) begin
         rd(bad[k], 32'h0, 2'h2);
         wr(bad[k], $urandom, 4'hF, 2'h2);
      end
      test_done;
   end
endmodule
